// ### core/rat_pkg.sv
// Package: constants of the resolution-adjust time measurement block
package rat_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RECOVERY_NS = 15;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALU_TIME_NS = 180;
  localparam int ALU_CYCLES = ALU_TIME_NS / CLK_PERIOD_NS;
  localparam int LOCK_DELAY_MS = 10;
  localparam int LOCK_CYCLES = (LOCK_DELAY_MS * 1000000) / CLK_PERIOD_NS;

  // ==========================================================
  // Measurement range in LSB
  localparam logic [15:0] RANGE_LSB = 16'h3C00;     // 15.360
  localparam logic [15:0] WRAP_LSB = 16'h7800;      // 30.720

  // ==========================================================
  // Control fields and reset values
  localparam int MODE_BIT = 7;                      // control 1
  localparam int SEARCH_BIT = 3;                    // register 4
  localparam int OVF_ROUTE_BIT = 7;                 // register 6
  localparam int LOCK_FLAG_BIT = 7;                 // status 1
  localparam int OVF_FLAG_BIT = 6;                  // status 1
  localparam int HIT_EN_CH1_LSB = 0;                // control 7, bits 2-0
  localparam int HIT_EN_CH2_LSB = 3;                // control 7, bits 5-3
  localparam logic [5:0] HIT_EN_RESET = 6'h24;      // 4 hits each
  localparam logic [2:0] MAX_HITS = 3'h4;
  localparam logic [7:0] MULT_RESET = 8'h64;
  localparam logic [7:0] MULT_TAKE_DERIVED = 8'hE1; // 225
  localparam logic [7:0] DUTY_HALF = 8'h80;
  localparam logic [7:0] DUTY_RESET = 8'h80;

  // ==========================================================
  // ALU selector codes
  localparam logic [3:0] SEL_CH1_BASE = 4'h1;
  localparam logic [3:0] SEL_CH2_BASE = 4'h9;
endpackage

// ### core/rat_stop_chan.sv
// Module: one stop channel with recovery gate and hit capture
`timescale 1ns/1ns
`default_nettype none
module rat_stop_chan #(
  parameter int REC_CYCLES = rat_pkg::RECOVERY_CYCLES
) (
  input wire logic clk_in,                 // clock
  input wire logic rst_n_in,               // async reset, active low
  input wire logic edge_in,                // synchronised stop edge pulse
  input wire logic arm_in,                 // start of a new measurement
  input wire logic [2:0] hit_en_in,        // enabled hit count
  input wire logic [15:0] time_in,         // current timebase value
  output logic accept_out,                 // edge taken this cycle
  output logic [2:0] count_out,            // hits captured
  output logic [3:0][15:0] stamps_out      // captured times
);
  logic [2:0] count_ff;
  logic [2:0] nxt_count;
  logic [3:0][15:0] stamps_ff;
  logic [3:0][15:0] nxt_stamps;
  logic [3:0] rec_ff;
  logic [3:0] nxt_rec;
  logic take;
  logic [2:0] limit;

  // ==========================================================
  // Capture
  always_comb begin
    limit = (hit_en_in > rat_pkg::MAX_HITS) ? rat_pkg::MAX_HITS : hit_en_in;
    take = edge_in && (rec_ff == 4'h0) && (count_ff < limit);     // R02 R24
    nxt_count = count_ff;
    nxt_stamps = stamps_ff;
    nxt_rec = (rec_ff != 4'h0) ? rec_ff - 4'h1 : 4'h0;
    // Recovery restarts on any edge, taken or not, as a real channel would
    if (edge_in) begin
      nxt_rec = 4'(REC_CYCLES - 1);                              // R02
    end
    if (arm_in) begin
      nxt_count = 3'h0;
    end else if (take) begin
      nxt_stamps[count_ff[1:0]] = time_in;
      nxt_count = count_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_ff <= 3'h0;
      stamps_ff <= '0;
      rec_ff <= 4'h0;
    end else begin
      count_ff <= nxt_count;
      stamps_ff <= nxt_stamps;
      rec_ff <= nxt_rec;
    end
  end

  assign accept_out = take && !arm_in;
  assign count_out = count_ff;
  assign stamps_out = stamps_ff;
endmodule
`default_nettype wire

// ### core/rat_top.sv
// Module: resolution-adjust time measurement core with PLL control
// Behaviour
// R01: No start input; the first stop on either channel starts the timebase.
// R02: A second event on one channel within 15 ns is not recognised.
// R03: Events on different channels need no separation.
// R04: Sources deliver all events within 15.360 LSB of the first one.
// R05: ALU subtracts any hit from any other; no calibration; multiply only if positive.
// R06: Selector holds two nibbles; result is lower-selected minus upper-selected hit.
// R07: Codes 1-4 pick channel 1 hits, 9-C channel 2 hits.
// R08: Result is 16 bits; calculation takes about 180 ns.
// R09: Host uses this mode only with measurement range 1.
// R10: No calibration values are generated while the mode is on.
// R11: Host subtracts lower hit from higher hit in high resolution.
// R12: Mode enable bit, off after reset.
// R13: Hit count per channel 1 to 4, default 4.
// R14: Lock flag rises about 10 ms after the loop locks.
// R15: Locked loop drives phase output with varying-duty clock.
// R16: Lock loss clears flag, floating resolution, relock automatically.
// R17: Search mode: open loop, 50 percent phase clock, derived multiplier.
// R18: Multiplier written 225 then search off applies the derived value.
// R19: Timeout only sets a flag; hits still accepted until count reached.
// R20: ALU values above 15.360 LSB get 30.720 LSB subtracted.
// R21: Overflow flag in status bit 6, routable to the interrupt pin.
// R22: Host adds 30.720 LSB to negative or overflow-flagged results.
// R23: RLC measurements may run without leaving the mode.
// R24: Hits beyond the enabled count are ignored until rearmed.
`timescale 1ns/1ns
`default_nettype none
module rat_top #(
  parameter int LOCK_CYCLES = rat_pkg::LOCK_CYCLES,
  parameter int ALU_CYCLES = rat_pkg::ALU_CYCLES
) (
  input wire logic clk_in,                    // 100 MHz clock
  input wire logic rst_n_in,                  // async reset, active low
  input wire logic stop1_in,                  // stop pin channel 1, rising edge
  input wire logic stop2_in,                  // stop pin channel 2, rising edge
  input wire logic mode_en_in,                // resolution-adjust on
  input wire logic [5:0] hit_count_enable_in, // per channel hit counts
  input wire logic [7:0] alu_sel_in,          // two hit selector nibbles
  input wire logic mult_en_in,                // multiply positive results
  input wire logic [7:0] mult_factor_in,      // multiplier for results
  input wire logic arm_in,                    // arm a new measurement, pulse
  input wire logic alu_start_in,              // start ALU calculation, pulse
  input wire logic open_loop_search_mode_in,  // open-loop parameter search
  input wire logic mult_wr_in,                // write multiplier register, pulse
  input wire logic [7:0] mult_wr_data_in,     // multiplier write data
  input wire logic ovf_route_in,              // overflow flag to interrupt pin
  input wire logic pll_fast_in,               // loop comparator: core too fast
  input wire logic pll_in_range_in,           // loop within regulation range
  input wire logic cal_req_in,                // calibration request, pulse
  input wire logic rlc_req_in,                // RLC measurement request, pulse
  output logic [7:0] status_out,              // bit 7 lock, bit 6 overflow
  output logic timeout_out,                   // timeout flag
  output logic [15:0] result_out,             // ALU result
  output logic result_valid_out,              // result ready pulse
  output logic alu_busy_out,                  // calculation running
  output logic sel_err_out,                   // illegal selector code seen
  output logic [2:0] hits_ch1_out,            // hits captured channel 1
  output logic [2:0] hits_ch2_out,            // hits captured channel 2
  output logic phase_out,                     // loop phase clock
  output logic int_out,                       // interrupt pin
  output logic [7:0] resolution_multiplier_value_out, // active multiplier
  output logic [7:0] derived_mult_out,        // value found by search
  output logic cal_start_out,                 // calibration start, pulse
  output logic rlc_start_out                  // RLC start, pulse
);
  // ==========================================================
  // Pin synchronisers and edge detect
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [1:0] fast_ff;
  logic [1:0] range_ff;
  logic ev1;
  logic ev2;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      fast_ff <= 2'h0;
      range_ff <= 2'h0;
    end else begin
      s1_ff <= {s1_ff[1:0], stop1_in};
      s2_ff <= {s2_ff[1:0], stop2_in};
      fast_ff <= {fast_ff[0], pll_fast_in};
      range_ff <= {range_ff[0], pll_in_range_in};
    end
  end

  // Edges only count while the mode is on
  assign ev1 = mode_en_in && s1_ff[1] && !s1_ff[2];              // R12
  assign ev2 = mode_en_in && s2_ff[1] && !s2_ff[2];

  // ==========================================================
  // Timebase
  logic running_ff;
  logic nxt_running;
  logic [15:0] time_ff;
  logic [15:0] nxt_time;
  logic [15:0] elapsed_ff;
  logic [15:0] nxt_elapsed;
  logic timeout_ff;
  logic nxt_timeout;
  logic ovf_ff;
  logic nxt_ovf;
  logic [15:0] stamp_time;
  logic acc1;
  logic acc2;

  always_comb begin
    nxt_running = running_ff;
    nxt_time = time_ff;
    nxt_elapsed = elapsed_ff;
    nxt_timeout = timeout_ff;
    nxt_ovf = ovf_ff;
    if (arm_in) begin
      nxt_running = 1'b0;
      nxt_time = 16'h0000;
      nxt_elapsed = 16'h0000;
      nxt_timeout = 1'b0;
      nxt_ovf = 1'b0;
    end
    // Arm starts a new measurement, so it outranks the running count
    if (running_ff && !arm_in) begin
      nxt_time = time_ff + 16'h0001;
      if (elapsed_ff != 16'hFFFF) begin
        nxt_elapsed = elapsed_ff + 16'h0001;
      end
      // Flags only; measuring carries on past the range
      if (elapsed_ff >= rat_pkg::RANGE_LSB) begin
        nxt_timeout = 1'b1;                                       // R19
      end
      if (elapsed_ff >= rat_pkg::WRAP_LSB) begin
        nxt_ovf = 1'b1;                                           // R21
      end
    end else if ((acc1 || acc2) && !arm_in) begin
      nxt_running = 1'b1;                                         // R01
      nxt_time = 16'h0001;
      nxt_elapsed = 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      running_ff <= 1'b0;
      time_ff <= 16'h0000;
      elapsed_ff <= 16'h0000;
      timeout_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      running_ff <= nxt_running;
      time_ff <= nxt_time;
      elapsed_ff <= nxt_elapsed;
      timeout_ff <= nxt_timeout;
      ovf_ff <= nxt_ovf;
    end
  end

  // First event reads as time zero
  assign stamp_time = running_ff ? time_ff : 16'h0000;

  // ==========================================================
  // Stop channels, independent so no cross-channel spacing applies
  logic [2:0] cnt1;
  logic [2:0] cnt2;
  logic [3:0][15:0] st1;
  logic [3:0][15:0] st2;

  rat_stop_chan u_ch1 (                                           // R03
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .edge_in(ev1),
    .arm_in(arm_in),
    .hit_en_in(hit_count_enable_in[rat_pkg::HIT_EN_CH1_LSB +: 3]), // R13
    .time_in(stamp_time),
    .accept_out(acc1),
    .count_out(cnt1),
    .stamps_out(st1)
  );

  rat_stop_chan u_ch2 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .edge_in(ev2),
    .arm_in(arm_in),
    .hit_en_in(hit_count_enable_in[rat_pkg::HIT_EN_CH2_LSB +: 3]), // R13
    .time_in(stamp_time),
    .accept_out(acc2),
    .count_out(cnt2),
    .stamps_out(st2)
  );

  // ==========================================================
  // ALU
  function automatic logic [16:0] pick_hit(input logic [3:0] code,
                                           input logic [3:0][15:0] a,
                                           input logic [3:0][15:0] b);
    logic [3:0] idx;
    idx = 4'h0;
    pick_hit = 17'h00000;
    if (code >= rat_pkg::SEL_CH1_BASE && code < rat_pkg::SEL_CH1_BASE + 4'h4) begin
      idx = code - rat_pkg::SEL_CH1_BASE;                         // R07
      pick_hit = {1'b1, a[idx[1:0]]};
    end else if (code >= rat_pkg::SEL_CH2_BASE && code < rat_pkg::SEL_CH2_BASE + 4'h4) begin
      idx = code - rat_pkg::SEL_CH2_BASE;                         // R07
      pick_hit = {1'b1, b[idx[1:0]]};
    end
  endfunction

  logic busy_ff;
  logic nxt_busy;
  logic [7:0] alu_cnt_ff;
  logic [7:0] nxt_alu_cnt;
  logic [15:0] res_ff;
  logic [15:0] nxt_res;
  logic valid_ff;
  logic nxt_valid;
  logic err_ff;
  logic nxt_err;
  logic [16:0] lo_hit;
  logic [16:0] hi_hit;
  logic signed [17:0] diff;
  logic signed [17:0] adj;
  logic [23:0] prod;

  always_comb begin
    lo_hit = pick_hit(alu_sel_in[3:0], st1, st2);                 // R06
    hi_hit = pick_hit(alu_sel_in[7:4], st1, st2);                 // R06
    diff = $signed({2'b00, lo_hit[15:0]}) - $signed({2'b00, hi_hit[15:0]}); // R05
    adj = diff;
    if (diff > $signed({2'b00, rat_pkg::RANGE_LSB})) begin
      adj = diff - $signed({2'b00, rat_pkg::WRAP_LSB});           // R20
    end
    prod = adj[15:0] * mult_factor_in;
    nxt_busy = busy_ff;
    nxt_alu_cnt = alu_cnt_ff;
    nxt_res = res_ff;
    nxt_valid = 1'b0;
    nxt_err = err_ff;
    if (alu_start_in && !busy_ff) begin
      nxt_busy = 1'b1;
      nxt_alu_cnt = 8'(ALU_CYCLES - 1);                           // R08
      nxt_err = !(lo_hit[16] && hi_hit[16]);
    end else if (busy_ff) begin
      if (alu_cnt_ff == 8'h00) begin
        nxt_busy = 1'b0;
        nxt_valid = 1'b1;
        // No calibration step; multiply only a positive difference
        if (mult_en_in && adj > 18'sd0) begin
          nxt_res = prod[15:0];                                   // R05
        end else begin
          nxt_res = adj[15:0];                                    // R08
        end
      end else begin
        nxt_alu_cnt = alu_cnt_ff - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_ff <= 1'b0;
      alu_cnt_ff <= 8'h00;
      res_ff <= 16'h0000;
      valid_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      alu_cnt_ff <= nxt_alu_cnt;
      res_ff <= nxt_res;
      valid_ff <= nxt_valid;
      err_ff <= nxt_err;
    end
  end

  // ==========================================================
  // Loop: lock detect, phase clock, parameter search
  logic lock_ff;
  logic nxt_lock;
  logic [31:0] lock_cnt_ff;
  logic [31:0] nxt_lock_cnt;
  logic [7:0] pwm_ff;
  logic [7:0] nxt_pwm;
  logic [7:0] duty_ff;
  logic [7:0] nxt_duty;
  logic phase_ff;
  logic nxt_phase;
  logic [7:0] mult_ff;
  logic [7:0] nxt_mult;
  logic [7:0] derived_ff;
  logic [7:0] nxt_derived;
  logic search_d_ff;
  logic search_on;
  logic closed;

  always_comb begin
    search_on = mode_en_in && open_loop_search_mode_in;
    closed = mode_en_in && !open_loop_search_mode_in;
    nxt_lock = lock_ff;
    nxt_lock_cnt = lock_cnt_ff;
    if (!closed || !range_ff[1]) begin
      // Out of range: floating resolution, counter restarts for relock
      nxt_lock = 1'b0;                                            // R16
      nxt_lock_cnt = 32'h00000000;
    end else if (lock_cnt_ff >= 32'(LOCK_CYCLES - 1)) begin
      nxt_lock = 1'b1;                                            // R14
    end else begin
      nxt_lock_cnt = lock_cnt_ff + 32'h00000001;
    end
    nxt_pwm = pwm_ff + 8'h01;
    nxt_duty = duty_ff;
    nxt_derived = derived_ff;
    // One correction per phase period keeps the loop slow and stable
    if (pwm_ff == 8'hFF) begin
      if (closed) begin
        if (fast_ff[1] && duty_ff != 8'h00) begin
          nxt_duty = duty_ff - 8'h01;                             // R15
        end else if (!fast_ff[1] && duty_ff != 8'hFF) begin
          nxt_duty = duty_ff + 8'h01;                             // R15
        end
      end
      if (search_on) begin
        if (fast_ff[1] && derived_ff != 8'hFF) begin
          nxt_derived = derived_ff + 8'h01;                       // R17
        end else if (!fast_ff[1] && derived_ff != 8'h00) begin
          nxt_derived = derived_ff - 8'h01;                       // R17
        end
      end
    end
    if (search_on) begin
      nxt_phase = (nxt_pwm < rat_pkg::DUTY_HALF);                 // R17
    end else if (closed) begin
      nxt_phase = (nxt_pwm < duty_ff);                            // R15
    end else begin
      nxt_phase = 1'b0;
    end
    nxt_mult = mult_ff;
    if (mult_wr_in) begin
      nxt_mult = mult_wr_data_in;
    end else if (search_d_ff && !open_loop_search_mode_in
                 && mult_ff == rat_pkg::MULT_TAKE_DERIVED) begin
      nxt_mult = derived_ff;                                      // R18
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_ff <= 1'b0;
      lock_cnt_ff <= 32'h00000000;
      pwm_ff <= 8'h00;
      duty_ff <= rat_pkg::DUTY_RESET;
      phase_ff <= 1'b0;
      mult_ff <= rat_pkg::MULT_RESET;
      derived_ff <= rat_pkg::MULT_RESET;
      search_d_ff <= 1'b0;
    end else begin
      lock_ff <= nxt_lock;
      lock_cnt_ff <= nxt_lock_cnt;
      pwm_ff <= nxt_pwm;
      duty_ff <= nxt_duty;
      phase_ff <= nxt_phase;
      mult_ff <= nxt_mult;
      derived_ff <= nxt_derived;
      search_d_ff <= open_loop_search_mode_in;
    end
  end

  // ==========================================================
  // Side requests and registered outputs
  logic cal_ff;
  logic rlc_ff;
  logic int_ff;
  logic [2:0] h1_ff;
  logic [2:0] h2_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cal_ff <= 1'b0;
      rlc_ff <= 1'b0;
      int_ff <= 1'b0;
      h1_ff <= 3'h0;
      h2_ff <= 3'h0;
    end else begin
      cal_ff <= cal_req_in && !mode_en_in;                        // R10
      rlc_ff <= rlc_req_in;                                       // R23
      int_ff <= ovf_route_in && ovf_ff;                           // R21
      h1_ff <= cnt1;
      h2_ff <= cnt2;
    end
  end

  always_comb begin
    status_out = 8'h00;
    status_out[rat_pkg::LOCK_FLAG_BIT] = lock_ff;                 // R14
    status_out[rat_pkg::OVF_FLAG_BIT] = ovf_ff;                   // R21
  end

  assign timeout_out = timeout_ff;
  assign result_out = res_ff;
  assign result_valid_out = valid_ff;
  assign alu_busy_out = busy_ff;
  assign sel_err_out = err_ff;
  assign hits_ch1_out = h1_ff;
  assign hits_ch2_out = h2_ff;
  assign phase_out = phase_ff;
  assign int_out = int_ff;
  assign resolution_multiplier_value_out = mult_ff;
  assign derived_mult_out = derived_ff;
  assign cal_start_out = cal_ff;
  assign rlc_start_out = rlc_ff;
endmodule
`default_nettype wire

// ### testbench/rat_top_properties.sv
// Checker: port properties of the time measurement core
`timescale 1ns/1ns
`default_nettype none
module rat_top_chk #(
  parameter int LOCK_CYCLES = 20,
  parameter int ALU_CYCLES = 18
) (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic mode_en_in, // mode
  input wire logic arm_in, // arm
  input wire logic alu_start_in, // start
  input wire logic rlc_req_in, // rlc req
  input wire logic pll_in_range_in, // range
  input wire logic ovf_route_in, // route
  input wire logic [7:0] status_out, // status
  input wire logic timeout_out, // timeout
  input wire logic result_valid_out, // valid
  input wire logic alu_busy_out, // busy
  input wire logic [2:0] hits_ch1_out, // hits
  input wire logic phase_out, // phase
  input wire logic int_out, // int pin
  input wire logic cal_start_out, // cal
  input wire logic rlc_start_out // rlc
);
  localparam int ALU_LAT = ALU_CYCLES + 1;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ==========
  // ALU timing
  sequence alu_go;
    alu_start_in && !alu_busy_out;
  endsequence
  a_alu_latency: assert property (alu_go |-> ##ALU_LAT result_valid_out)
    else $error("late result");
  a_alu_busy: assert property (alu_go |=> alu_busy_out [*8])
    else $error("busy dropped");
  a_valid_end: assert property (result_valid_out |-> $past(alu_busy_out) && !alu_busy_out)
    else $error("stray result");
  // ==========
  // Flags and pins
  a_lock_loss: assert property ((!pll_in_range_in) [*5] |-> !status_out[7])
    else $error("lock kept");
  a_int_route: assert property (status_out[6] && ovf_route_in |=> int_out)
    else $error("int missing");
  a_arm_clear: assert property (arm_in |=> !timeout_out && !status_out[6])
    else $error("flags kept");
  a_no_cal: assert property (mode_en_in [*2] |-> !cal_start_out)
    else $error("cal in mode");
  a_rlc_pass: assert property (rlc_req_in |=> rlc_start_out)
    else $error("rlc lost");
  a_phase_idle: assert property ((!mode_en_in) [*3] |-> !phase_out)
    else $error("phase active");
  a_hits_frozen: assert property ((!mode_en_in) [*5] |-> hits_ch1_out <= $past(hits_ch1_out))
    else $error("hit while off");
endmodule
`default_nettype wire

// ### testbench/rat_stop_src.sv
// Partner: stop pulse sources firing one clean pulse per request
`timescale 1ns/1ns
`default_nettype none
module rat_stop_src (
  input wire logic clk_in, // clock
  input wire logic fire1_in, // fire ch1
  input wire logic fire2_in, // fire ch2
  output logic stop1_out, // stop ch1
  output logic stop2_out // stop ch2
);
  initial begin
    stop1_out = 1'h0;
    stop2_out = 1'h0;
  end
  // Bench keeps every fire_seq burst inside the capture range; the late-hit case fires past it
  always @(posedge clk_in) begin
    stop1_out <= #1 fire1_in;
    stop2_out <= #1 fire2_in;
  end
endmodule
`default_nettype wire

// ### testbench/tb_rat_top.sv
// Testbench: row table and directed cases for the time measurement core
`timescale 1ns/1ns
`default_nettype none
module tb_rat_top;
  typedef struct packed {
    logic [5:0] en;
    logic [2:0] h1;
    logic [2:0] h2;
    logic [7:0] sel;
    logic men;
    logic [15:0] res;
  } rat_row_t;
  logic clk_in = 1'h0, rst_n_in = 1'h0, fire1 = 1'h0, fire2 = 1'h0;
  wire logic stop1_in, stop2_in;
  logic mode_en_in = 1'h0, mult_en_in = 1'h0, arm_in = 1'h0, alu_start_in = 1'h0;
  logic open_loop_search_mode_in = 1'h0, mult_wr_in = 1'h0, ovf_route_in = 1'h1;
  logic pll_fast_in = 1'h0, pll_in_range_in = 1'h1, cal_req_in = 1'h0, rlc_req_in = 1'h0;
  logic [5:0] hit_count_enable_in = 6'h24;
  logic [7:0] alu_sel_in = 8'h21, mult_factor_in = 8'h03, mult_wr_data_in = 8'hE1;
  logic [7:0] status_out, resolution_multiplier_value_out, derived_mult_out;
  logic [15:0] result_out, hi;
  logic [2:0] hits_ch1_out, hits_ch2_out;
  logic timeout_out, result_valid_out, alu_busy_out, sel_err_out, phase_out;
  logic int_out, cal_start_out, rlc_start_out;
  int error_cnt = 0, total_checks = 0, lat;
  // Hits land at ch1 0,4,8,12 and ch2 0,5,10,15
  rat_row_t rows [8] = '{
    '{6'h24, 3'h4, 3'h4, 8'h21, 1'h0, 16'hFFFC},
    '{6'h24, 3'h4, 3'h4, 8'hA3, 1'h0, 16'h0003},
    '{6'h24, 3'h4, 3'h4, 8'h4B, 1'h0, 16'hFFFE},
    '{6'h24, 3'h4, 3'h4, 8'h14, 1'h1, 16'h0024},
    '{6'h24, 3'h4, 3'h4, 8'h21, 1'h1, 16'hFFFC},
    '{6'h11, 3'h1, 3'h2, 8'h9A, 1'h0, 16'h0005},
    '{6'h1B, 3'h3, 3'h3, 8'h3B, 1'h0, 16'h0002},
    '{6'h09, 3'h1, 3'h1, 8'h91, 1'h0, 16'h0000}
  };
  rat_stop_src src_u (.clk_in(clk_in), .fire1_in(fire1), .fire2_in(fire2),
    .stop1_out(stop1_in), .stop2_out(stop2_in));
  rat_top #(.LOCK_CYCLES(20)) dut_u (.*);
  always #5 clk_in = ~clk_in;
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic arm_pulse();
    step(1);
    arm_in = 1'h1;
    step(1);
    arm_in = 1'h0;
  endtask
  // Surplus pulses probe the enabled-count limit
  task automatic fire_seq();
    for (int k = 0; k < 24; k++) begin
      step(1);
      fire1 = (k % 4 == 0);
      fire2 = (k % 5 == 0);
    end
    step(6);
  endtask
  task automatic run_alu(input logic [7:0] sel, input logic men);
    alu_sel_in = sel;
    mult_en_in = men;
    step(1);
    alu_start_in = 1'h1;
    step(1);
    alu_start_in = 1'h0;
    lat = 0;
    while (result_valid_out !== 1'h1 && lat < 40) begin
      step(1);
      lat++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    step(16);
    chk("status rst", 16'h0000, 16'(status_out));
    chk("mult rst", 16'h0064, 16'(resolution_multiplier_value_out));
    rst_n_in = 1'h1;
    fire_seq();
    chk("hits off", 16'h0000, 16'(hits_ch1_out));
    mode_en_in = 1'h1;
    step(5);
    chk("lock early", 16'h0000, 16'(status_out[7]));
    step(30);
    chk("lock", 16'h0001, 16'(status_out[7]));
    pll_in_range_in = 1'h0;
    step(6);
    chk("lock lost", 16'h0000, 16'(status_out[7]));
    pll_in_range_in = 1'h1;
    step(30);
    chk("relock", 16'h0001, 16'(status_out[7]));
    foreach (rows[i]) begin
      hit_count_enable_in = rows[i].en;
      arm_pulse();
      fire_seq();
      chk("hits1", 16'(rows[i].h1), 16'(hits_ch1_out));
      chk("hits2", 16'(rows[i].h2), 16'(hits_ch2_out));
      run_alu(rows[i].sel, rows[i].men);
      chk("alu lat", 16'(rat_pkg::ALU_CYCLES), 16'(lat));
      chk("alu res", rows[i].res, result_out);
      chk("sel ok", 16'h0000, 16'(sel_err_out));
    end
    hit_count_enable_in = 6'h12;
    arm_pulse();
    fire1 = 1'h1;
    step(1);
    fire1 = 1'h0;
    step(15999);
    chk("timeout", 16'h0001, 16'(timeout_out));
    fire1 = 1'h1;
    step(1);
    fire1 = 1'h0;
    step(6);
    chk("late hit", 16'h0002, 16'(hits_ch1_out));
    run_alu(8'h12, 1'h0);
    chk("wrap", 16'hC680, result_out);
    chk("host fix", 16'h3E80, result_out + rat_pkg::WRAP_LSB);
    run_alu(8'h15, 1'h0);
    chk("sel bad", 16'h0001, 16'(sel_err_out));
    step(15000);
    chk("ovf", 16'h0001, 16'(status_out[6]));
    chk("int", 16'h0001, 16'(int_out));
    arm_pulse();
    step(2);
    chk("timeout clr", 16'h0000, 16'(timeout_out));
    open_loop_search_mode_in = 1'h1;
    pll_fast_in = 1'h1;
    step(512);
    hi = 16'h0000;
    repeat (256) begin
      step(1);
      hi = hi + 16'(phase_out);
    end
    chk("duty", 16'h0080, hi);
    chk("derived", 16'h0001, 16'(derived_mult_out > 8'h64));
    mult_wr_in = 1'h1;
    step(1);
    mult_wr_in = 1'h0;
    step(2);
    chk("mult wr", 16'h00E1, 16'(resolution_multiplier_value_out));
    open_loop_search_mode_in = 1'h0;
    step(4);
    chk("mult use", 16'(derived_mult_out), 16'(resolution_multiplier_value_out));
    for (int m = 1; m >= 0; m--) begin
      mode_en_in = m[0];
      cal_req_in = 1'h1;
      rlc_req_in = 1'h1;
      step(1);
      cal_req_in = 1'h0;
      rlc_req_in = 1'h0;
      chk("cal", 16'(!m[0]), 16'(cal_start_out));
      chk("rlc", 16'h0001, 16'(rlc_start_out));
      step(6);
    end
    end_sim();
  end
  // Run needs about 32k cycles
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    end_sim();
  end
endmodule
bind rat_top rat_top_chk #(.LOCK_CYCLES(LOCK_CYCLES), .ALU_CYCLES(ALU_CYCLES)) chk_u (.*);
`default_nettype wire
